/* File: verilog/companding_sar_sequencer.sv */
// Successive-approximation sequencer that drives the converter as an encoder
`timescale 1ns/100ps
`include "companding_map.svh"
// How it works
// R01: Encode select high chooses encode outputs
// R02: Encode select low chooses decode outputs
// R03: All-ones magnitude gives full-scale current
// R04: Sign and select route to four outputs
// R05: Sign plus chord gives sixteen segments
// R06: Sixteen equal steps, size doubles per chord
// R07: Select may act as ninth decode bit
// R08: First pulse clears MSB, sets others
// R09: First pulse drives encode select low
// R10: Comparator through XOR, inverted when negative
// R11: Magnitude coding uniform for either polarity
// R12: Second pulse raises select, loads sign
// R13: Nine pulses yield eight-bit code
// R14: Analog input held constant during conversion
// R15: Sign one gives positive output
// R16: Chord and step fields coded binary
// R17: Magnitude MSB first, chord then step
// R18: Done after ninth pulse, result held
module companding_sar_sequencer
  import companding_pkg::*;
#(
  parameter int CLK_DIV = `CLK_DIV_DEFAULT
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // User side
  input wire logic startn,
  output logic conversion_done_flag,
  output logic [`CODE_WIDTH-1:0] codeOut,
  // Converter side
  companding_if.sequencer link
);
  // ==========================================
  // Conversion clock divider
  logic [15:0] divCount_r;
  logic convPulse;
  assign convPulse = (divCount_r == 16'(CLK_DIV - 1));
  // One-cycle enable stands in for the slow conversion clock
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      divCount_r <= 16'h0000;
    end else if (convPulse) begin
      divCount_r <= 16'h0000;
    end else begin
      divCount_r <= divCount_r + 16'h0001;
    end
  end

  // ==========================================
  // Sequencer state
  seq_state_type state_r;
  logic [3:0] pulseCount_r;
  logic [`CODE_WIDTH-1:0] sar_r;
  logic encodeSel_r;
  logic negative_r;
  logic serialIn;
  logic [2:0] bitIdx;
  logic accept;
  logic finalPulse;

  // ==========================================
  // Decode helpers
  // Start is honoured only between conversions; a low start mid-conversion is
  // ignored without any indication, so a user must wait for the done flag
  function automatic logic startTaken(input seq_state_type st, input logic startLow);
    startTaken = startLow && (st == SEQ_IDLE || st == SEQ_DONE);
  endfunction

  // The ninth pulse decides the last magnitude bit and ends the conversion
  function automatic logic lastPulse(input seq_state_type st, input logic [3:0] count);
    lastPulse = (st == SEQ_BITS) && (count == `CONV_PULSES - `PULSE_ONE);
  endfunction

  // Inversion for negative inputs keeps all-ones meaning full scale both ways
  assign serialIn = link.compareHigh ^ negative_r; // R10 R11
  // Count two (third pulse) trials bit six, count eight (ninth pulse) bit zero
  assign bitIdx = 3'(`CODE_WIDTH - pulseCount_r);
  assign accept = convPulse && startTaken(state_r, !startn);
  assign finalPulse = convPulse && lastPulse(state_r, pulseCount_r);

  // ==========================================
  // Sequencing
  // State: idle, polarity decision, seven bit trials, result held
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= SEQ_IDLE;
    end else if (accept) begin
      state_r <= SEQ_POLARITY;
    end else if (convPulse) begin
      case (state_r)
        SEQ_POLARITY: begin
          state_r <= SEQ_BITS;
        end
        SEQ_BITS: begin
          if (finalPulse) begin
            state_r <= SEQ_DONE; // R13 R18
          end
        end
        SEQ_IDLE, SEQ_DONE: begin
          state_r <= state_r;
        end
        default: begin
          state_r <= SEQ_IDLE;
        end
      endcase
    end
  end

  // Pulse count: the accepting pulse is number one, the ninth ends the work;
  // it rests at nine after a conversion, which no decode treats as live
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pulseCount_r <= 4'h0;
    end else if (accept) begin
      pulseCount_r <= `PULSE_ONE;
    end else if (convPulse && (state_r == SEQ_POLARITY || state_r == SEQ_BITS)) begin
      pulseCount_r <= pulseCount_r + `PULSE_ONE; // R13
    end
  end

  // Select flip-flop: low for the polarity decision only, so no encode current flows
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      encodeSel_r <= 1'b1;
    end else if (accept) begin
      encodeSel_r <= 1'b0; // R09
    end else if (convPulse && state_r == SEQ_POLARITY) begin
      encodeSel_r <= 1'b1; // R12
    end
  end

  // Polarity flip-flop feeds the second input of the inverting gate; it is
  // cleared on accept so the sign decision itself is never inverted
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      negative_r <= 1'b0;
    end else if (accept) begin
      negative_r <= 1'b0; // R10
    end else if (convPulse && state_r == SEQ_POLARITY) begin
      negative_r <= ~link.compareHigh; // R10
    end
  end

  // ==========================================
  // Successive-approximation register
  // Trial pattern on accept, then the kept decision per pulse
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sar_r <= 8'h00;
    end else if (accept) begin
      sar_r <= {1'b0, `FULL_MAG}; // R08
    end else if (convPulse) begin
      case (state_r)
        SEQ_POLARITY: begin
          sar_r[`SIGN_POS] <= serialIn; // R12 R15
        end
        SEQ_BITS: begin
          // Keep decision on current trial bit, then trial next lower bit
          sar_r[bitIdx] <= serialIn; // R13 R17
          if (bitIdx != 3'h0) begin
            sar_r[bitIdx - 3'h1] <= 1'b1;
          end
        end
        SEQ_IDLE, SEQ_DONE: begin
          // Result stays in place until the next start is taken
          sar_r <= sar_r; // R18
        end
        default: begin
          sar_r <= sar_r;
        end
      endcase
    end
  end

  // Note: during bit trials the lower bits already sit at one from the first pulse,
  // so the trial pattern is decision bits, current bit one, the rest zeroed below.
  logic [`MAG_WIDTH-1:0] trialMag;
  always_comb begin
    trialMag = sar_r[`MAG_WIDTH-1:0];
    if (state_r == SEQ_BITS) begin
      for (int i = 0; i < `MAG_WIDTH; i++) begin
        if (i < int'(bitIdx)) begin
          trialMag[i] = 1'b0;
        end
      end
    end
  end

  // ==========================================
  // Result and link outputs
  // Result register: loaded on the ninth pulse, held until the next one
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      codeOut <= 8'h00;
    end else if (finalPulse) begin
      codeOut <= {sar_r[`CODE_WIDTH-1:1], serialIn}; // R18
    end
  end

  assign conversion_done_flag = (state_r == SEQ_DONE); // R18
  assign link.encodeSelect = encodeSel_r; // R09 R12
  assign link.signBit = sar_r[`SIGN_POS];
  assign link.magnitude = trialMag; // R17
  // Sample-and-hold ahead of the comparator is left to the analog side  R14
endmodule

/* File: include/companding_map.svh */
// Constants for the companding converter and its successive-approximation sequencer
`ifndef COMPANDING_MAP_SVH
`define COMPANDING_MAP_SVH
`define MAG_WIDTH 7
`define CHORD_WIDTH 3
`define STEP_WIDTH 4
`define CODE_WIDTH 8
`define LEVEL_WIDTH 14
`define CHORD_MSB 6
`define CHORD_LSB 4
`define STEP_MSB 3
`define STEP_LSB 0
`define SIGN_POS 7
`define FULL_MAG 7'h7F
`define ZERO_MAG 7'h00
`define CONV_PULSES 4'h9
`define PULSE_ONE 4'h1
`define CLK_DIV_DEFAULT 8
`define BIAS_BASE 14'h0021
`endif

/* File: include/companding_pkg.sv */
// Types shared by the converter end and the sequencer end
package companding_pkg;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h0,
    SEQ_POLARITY = 3'h1,
    SEQ_BITS = 3'h3,
    SEQ_DONE = 3'h2
  } seq_state_type;
endpackage

/* File: include/companding_if.sv */
// Digital link between the converter and its successive-approximation sequencer
`timescale 1ns/100ps
`include "companding_map.svh"
interface companding_if;
  logic encodeSelect;
  logic signBit;
  logic [`MAG_WIDTH-1:0] magnitude;
  logic compareHigh;
  modport converter (input encodeSelect, input signBit, input magnitude, output compareHigh);
  modport sequencer (output encodeSelect, output signBit, output magnitude, input compareHigh);
endinterface

/* File: verilog/companding_converter.sv */
// Digital model of the companding converter: output routing, level and comparison
`timescale 1ns/100ps
`include "companding_map.svh"
module companding_converter
  import companding_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Analog input as a signed level in half-step units
  input wire logic signed [`LEVEL_WIDTH:0] analogIn,
  // Current outputs as levels in half-step units
  output logic [`LEVEL_WIDTH-1:0] encode_out_pos,
  output logic [`LEVEL_WIDTH-1:0] encode_out_neg,
  output logic [`LEVEL_WIDTH-1:0] decode_out_pos,
  output logic [`LEVEL_WIDTH-1:0] decode_out_neg,
  // Sequencer side
  companding_if.converter link
);
  // ==========================================
  // Companded level: chord offset plus doubled step size
  function automatic logic [`LEVEL_WIDTH-1:0] decodeLevel(input logic [`MAG_WIDTH-1:0] mag);
    logic [`CHORD_WIDTH-1:0] chord;
    logic [`STEP_WIDTH-1:0] step;
    logic [`LEVEL_WIDTH-1:0] base;
    chord = mag[`CHORD_MSB:`CHORD_LSB]; // R16 R17
    step = mag[`STEP_MSB:`STEP_LSB]; // R16
    base = (`BIAS_BASE << chord) - `BIAS_BASE; // R05
    // Shift count is a bit wider than the chord, so the top chord still shifts by eight
    decodeLevel = base + (14'({10'h000, step}) << (4'(chord) + 4'h1)); // R06 R03
  endfunction
  // Encode adds half a step of the chord
  function automatic logic [`LEVEL_WIDTH-1:0] halfStep(input logic [`MAG_WIDTH-1:0] mag);
    halfStep = 14'h0001 << mag[`CHORD_MSB:`CHORD_LSB];
  endfunction

  logic [`LEVEL_WIDTH-1:0] level;
  assign level = decodeLevel(link.magnitude) + (link.encodeSelect ? halfStep(link.magnitude) : 14'h0000);

  // Output routing registered from the select and sign pins
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      encode_out_pos <= 14'h0000;
      encode_out_neg <= 14'h0000;
      decode_out_pos <= 14'h0000;
      decode_out_neg <= 14'h0000;
    end else begin
      encode_out_pos <= (link.encodeSelect && link.signBit) ? level : 14'h0000; // R01 R04 R15
      encode_out_neg <= (link.encodeSelect && !link.signBit) ? level : 14'h0000; // R01 R04
      decode_out_pos <= (!link.encodeSelect && link.signBit) ? level : 14'h0000; // R02 R04 R15
      decode_out_neg <= (!link.encodeSelect && !link.signBit) ? level : 14'h0000; // R02 R04
    end
  end

  // Comparator: in decode the input is tested against ground, else against the current
  logic signed [`LEVEL_WIDTH:0] ref_lvl;
  always_comb begin
    if (!link.encodeSelect) begin
      ref_lvl = '0;
    end else if (link.signBit) begin
      ref_lvl = $signed({1'b0, level});
    end else begin
      ref_lvl = -$signed({1'b0, level});
    end
  end
  assign link.compareHigh = (analogIn >= ref_lvl);
endmodule

/* File: dv/companding_link_sva.sv */
// Checker on the converter link and the result outputs
`timescale 1ns/100ps
module companding_link_sva (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Link
  input wire logic encodeSelect,
  input wire logic signBit,
  input wire logic [6:0] magnitude,
  input wire logic compareHigh,
  // Outputs
  input wire logic conversion_done_flag,
  input wire logic [7:0] codeOut,
  input wire logic [13:0] encode_out_pos,
  input wire logic [13:0] encode_out_neg,
  input wire logic [13:0] decode_out_pos,
  input wire logic [13:0] decode_out_neg
);
  // ==========================
  // Clocking and level model
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Encode adds half a chord step, so every encode level is odd
  function automatic logic [13:0] lvl(logic [6:0] m, logic enc);
    lvl = 14'(((2 * m[3:0] + 33) << m[6:4]) - 33 + (int'(enc) << m[6:4]));
  endfunction
  // Polarity phase lasts one pulse with CLK_DIV of 2
  sequence polarity_phase;
    !encodeSelect [*2] ##1 encodeSelect;
  endsequence
  // ==========================
  // Properties
  chk_encode_route: assert property (encodeSelect && signBit
    |=> encode_out_pos == lvl($past(magnitude), 1'b1)
    && encode_out_neg == 0 && decode_out_pos == 0 && decode_out_neg == 0) else $error("encode output wrong");
  chk_encode_negative: assert property (encodeSelect && !signBit
    |=> encode_out_neg == lvl($past(magnitude), 1'b1)
    && encode_out_pos == 0 && decode_out_pos == 0 && decode_out_neg == 0) else $error("negative encode output wrong");
  chk_decode_route: assert property (!encodeSelect && !signBit |=> decode_out_neg == lvl($past(magnitude), 1'b0)
    && encode_out_pos == 0 && encode_out_neg == 0) else $error("decode output wrong");
  chk_polarity_start: assert property ($fell(encodeSelect) |-> !signBit && magnitude == 7'h7F)
    else $error("first pulse pattern wrong");
  chk_select_return: assert property ($fell(encodeSelect) |-> polarity_phase) else $error("select not back");
  chk_done_latency: assert property ($fell(encodeSelect) |-> polarity_phase ##14 $rose(conversion_done_flag))
    else $error("done not after nine pulses");
  chk_sign_capture: assert property ($rose(encodeSelect) |-> signBit == $past(compareHigh))
    else $error("sign not from comparator");
  chk_result_held: assert property (conversion_done_flag && $past(conversion_done_flag) |-> $stable(codeOut))
    else $error("result moved");
  chk_code_sign: assert property ($rose(conversion_done_flag) |-> codeOut[7] == signBit)
    else $error("result sign wrong");
endmodule

/* File: dv/test_companding_dac_sar_encoder.sv */
// Self-checking bench for the converter and its sequencer
`timescale 1ns/100ps
module test_companding_dac_sar_encoder;
  logic ref_clk;
  logic resetn;
  logic startn;
  logic signed [14:0] analogIn;
  logic conversion_done_flag;
  logic [7:0] codeOut;
  logic [13:0] encode_out_pos, encode_out_neg, decode_out_pos, decode_out_neg;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  // Even inputs never sit on an encode level, so both polarities code alike
  int levels [9] = '{0, 9000, -9000, 500, -500, 4, -4, 2000, -16};
  companding_if link ();
  companding_sar_sequencer #(.CLK_DIV(2)) u_companding_sar_sequencer (.ref_clk, .resetn, .startn,
    .conversion_done_flag, .codeOut, .link(link.sequencer));
  companding_converter u_companding_converter (.ref_clk, .resetn, .analogIn, .encode_out_pos,
    .encode_out_neg, .decode_out_pos, .decode_out_neg, .link(link.converter));
  companding_link_sva u_companding_link_sva (.ref_clk, .resetn, .encodeSelect(link.encodeSelect),
    .signBit(link.signBit), .magnitude(link.magnitude), .compareHigh(link.compareHigh),
    .conversion_done_flag, .codeOut, .encode_out_pos, .encode_out_neg, .decode_out_pos, .decode_out_neg);
  // ==========================
  // Clock and timeout
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      tally_and_finish();
    end
  end
  // ==========================
  // Helpers
  function automatic logic [7:0] expCode(int x);
    int a;
    int m;
    a = (x < 0) ? -x : x;
    expCode = {x >= 0, 7'h00};
    for (m = 1; m < 128; m++) begin
      if (((2 * (m % 16) + 34) << (m / 16)) - 33 <= a) begin
        expCode[6:0] = 7'(m);
      end
    end
  endfunction
  task automatic check(input logic ok, input string what);
    checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  // Start is released once the select drop from the accepting pulse shows it was taken
  task automatic convert(input int x);
    analogIn = 15'(x);
    startn = 1'b0;
    do begin
      @(posedge ref_clk);
      #1;
    end while (link.encodeSelect !== 1'b0);
    startn = 1'b1;
    do begin
      @(posedge ref_clk);
      #1;
    end while (conversion_done_flag !== 1'b1);
    check(codeOut === expCode(x), "code");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================
  // Main sequence, conversions run back to back
  initial begin
    resetn = 1'b0;
    startn = 1'b1;
    analogIn = '0;
    repeat (3) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    check(link.encodeSelect === 1'b1 && conversion_done_flag === 1'b0, "reset");
    foreach (levels[i]) begin
      convert(levels[i]);
    end
    tally_and_finish();
  end
endmodule
